/* hw/dpd_pkg.sv */
`default_nettype none
package dpd_pkg;
  // Serial programming word
  localparam int unsigned WORD_W     = 22;
  localparam int unsigned SEL_W      = 2;
  localparam int unsigned NUM_WORDS  = 4;
  localparam logic [21:0] WORD_RESET = 22'h000000;

  // Word select codes (last two bits shifted in)
  localparam logic [1:0] SEL_REF_ONE  = 2'h0;
  localparam logic [1:0] SEL_REF_TWO  = 2'h1;
  localparam logic [1:0] SEL_FB_ONE   = 2'h2;
  localparam logic [1:0] SEL_FB_TWO   = 2'h3;

  // Reference word fields
  localparam int unsigned REF_W      = 15;
  localparam int unsigned REF_LSB    = 2;
  // Feedback word fields
  localparam int unsigned SWAL_W     = 7;
  localparam int unsigned SWAL_LSB   = 2;
  localparam int unsigned BIN_W      = 11;
  localparam int unsigned BIN_LSB    = 9;
  localparam int unsigned PSEL_BIT   = 20;
  localparam int unsigned POWER_DOWN_BIT_BIT   = 21;

  // Prescaler moduli
  localparam int unsigned PRE_W      = 8;
  localparam logic [7:0] PRE_LOW     = 8'h40;
  localparam logic [7:0] PRE_HIGH    = 8'h80;

  // Register bus
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 32;
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_WORD0   = 8'h04;
  localparam logic [7:0] OFF_WORD1   = 8'h08;
  localparam logic [7:0] OFF_WORD2   = 8'h0c;
  localparam logic [7:0] OFF_WORD3   = 8'h10;
  localparam logic [7:0] OFF_STATUS  = 8'h14;
  localparam logic [1:0] CTRL_RESET  = 2'h0;
  localparam int unsigned CTRL_HOLD_ONE = 0;
  localparam int unsigned CTRL_HOLD_TWO = 1;
endpackage
`default_nettype wire

/* hw/dpd_chan.sv */
`default_nettype none
module dpd_chan (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        ref_tick,
  input  wire logic        rf_tick,
  input  wire logic [14:0] ref_divide_value,
  input  wire logic [6:0]  swallow_count,
  input  wire logic [10:0] binary_count,
  input  wire logic        presc_high,
  input  wire logic        run,
  output logic             ref_compare_pulse,
  output logic             feedback_compare_pulse,
  output logic             pump_up,
  output logic             pump_down
);
  logic [14:0] ref_cnt_reg;
  logic [7:0]  pre_cnt_reg;
  logic [6:0]  swal_cnt_reg;
  logic [10:0] bin_cnt_reg;
  logic [7:0]  modulus;
  logic        pre_tick;
  logic        fb_end;

  // Reference divider, 15-bit, divide by R
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ref_cnt_reg       <= 15'h0000;
      ref_compare_pulse <= 1'b0;
    end else if (!run) begin
      ref_cnt_reg       <= 15'h0000;
      ref_compare_pulse <= 1'b0;
    end else if (ref_tick && ref_cnt_reg >= ref_divide_value - 15'h0001) begin
      ref_cnt_reg       <= 15'h0000;
      ref_compare_pulse <= 1'b1;
    end else begin
      if (ref_tick) begin
        ref_cnt_reg <= ref_cnt_reg + 15'h0001;
      end
      ref_compare_pulse <= 1'b0;
    end
  end

  // Swallow phase uses P+1, then P
  always_comb begin
    modulus = presc_high ? dpd_pkg::PRE_HIGH : dpd_pkg::PRE_LOW;
    if (swal_cnt_reg != 7'h00) begin
      modulus = modulus + 8'h01;
    end
  end

  assign pre_tick = rf_tick && (pre_cnt_reg >= modulus - 8'h01);
  assign fb_end   = pre_tick && (bin_cnt_reg >= binary_count - 11'h001);

  // Prescaler
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pre_cnt_reg <= 8'h00;
    end else if (!run || pre_tick) begin
      pre_cnt_reg <= 8'h00;
    end else if (rf_tick) begin
      pre_cnt_reg <= pre_cnt_reg + 8'h01;
    end
  end

  // Swallow and binary counters clocked by ref_clk, stepped by prescaler output pre_tick
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      swal_cnt_reg           <= 7'h00;
      bin_cnt_reg            <= 11'h000;
      feedback_compare_pulse <= 1'b0;
    end else if (!run) begin
      swal_cnt_reg           <= swallow_count;
      bin_cnt_reg            <= 11'h000;
      feedback_compare_pulse <= 1'b0;
    end else if (fb_end) begin
      swal_cnt_reg           <= swallow_count;
      bin_cnt_reg            <= 11'h000;
      feedback_compare_pulse <= 1'b1;
    end else begin
      if (pre_tick) begin
        bin_cnt_reg <= bin_cnt_reg + 11'h001;
        if (swal_cnt_reg != 7'h00) begin
          swal_cnt_reg <= swal_cnt_reg - 7'h01;
        end
      end
      feedback_compare_pulse <= 1'b0;
    end
  end

  // Phase/frequency detector
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pump_up   <= 1'b0;
      pump_down <= 1'b0;
    end else if (!run) begin
      pump_up   <= 1'b0;
      pump_down <= 1'b0;
    end else begin
      logic up_next;
      logic dn_next;
      up_next = pump_up | ref_compare_pulse;
      dn_next = pump_down | feedback_compare_pulse;
      if (up_next && dn_next) begin
        pump_up   <= 1'b0;
        pump_down <= 1'b0;
      end else begin
        pump_up   <= up_next;
        pump_down <= dn_next;
      end
    end
  end
endmodule
`default_nettype wire

/* hw/dpd_top.sv */
`default_nettype none
module dpd_top (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        serial_clock,
  input  wire logic        serial_data,
  input  wire logic        latch_strobe,
  input  wire logic        ref_clock_in,
  input  wire logic        rf_in_one,
  input  wire logic        rf_in_two,
  input  wire logic [7:0]  bus_addr,
  input  wire logic [31:0] bus_wdata,
  input  wire logic        bus_write,
  input  wire logic        bus_read,
  output logic      [31:0] bus_rdata,
  output logic      [1:0]  ref_compare_pulse,
  output logic      [1:0]  feedback_compare_pulse,
  output logic      [1:0]  pump_up,
  output logic      [1:0]  pump_down
);
  logic [21:0] shift_reg;
  logic [21:0] word_reg [4];
  logic        sclk_prev_reg;
  logic        latch_prev_reg;
  logic [1:0]  ctrl_reg;
  logic [1:0]  run;

  function automatic logic rose(input logic cur, input logic prev);
    rose = cur & ~prev;
  endfunction

  // Serial front end, inputs already synchronous to ref_clk
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sclk_prev_reg  <= 1'b0;
      latch_prev_reg <= 1'b0;
    end else begin
      sclk_prev_reg  <= serial_clock;
      latch_prev_reg <= latch_strobe;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      shift_reg <= dpd_pkg::WORD_RESET;
    end else if (rose(serial_clock, sclk_prev_reg)) begin
      shift_reg <= {shift_reg[20:0], serial_data};
    end
  end

  // Loaded regardless of power-down state
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < dpd_pkg::NUM_WORDS; i++) begin
        word_reg[i] <= dpd_pkg::WORD_RESET;
      end
    end else if (rose(latch_strobe, latch_prev_reg)) begin
      word_reg[shift_reg[1:0]] <= shift_reg;
    end
  end

  // Software control register
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg <= dpd_pkg::CTRL_RESET;
    end else if (bus_write && bus_addr == dpd_pkg::OFF_CTRL) begin
      ctrl_reg <= bus_wdata[1:0];
    end
  end

  // Read data valid the cycle after the strobe only
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bus_rdata <= 32'h00000000;
    end else if (bus_read) begin
      unique case (bus_addr)
        dpd_pkg::OFF_CTRL:   bus_rdata <= {30'h00000000, ctrl_reg};
        dpd_pkg::OFF_WORD0:  bus_rdata <= {10'h000, word_reg[0]};
        dpd_pkg::OFF_WORD1:  bus_rdata <= {10'h000, word_reg[1]};
        dpd_pkg::OFF_WORD2:  bus_rdata <= {10'h000, word_reg[2]};
        dpd_pkg::OFF_WORD3:  bus_rdata <= {10'h000, word_reg[3]};
        dpd_pkg::OFF_STATUS: bus_rdata <= {24'h000000, pump_down, pump_up, ~run, run};
        default:             bus_rdata <= 32'h00000000;
      endcase
    end else begin
      bus_rdata <= 32'h00000000;
    end
  end

  assign run[0] = ~word_reg[dpd_pkg::SEL_FB_ONE][dpd_pkg::POWER_DOWN_BIT_BIT] & ~ctrl_reg[dpd_pkg::CTRL_HOLD_ONE];
  assign run[1] = ~word_reg[dpd_pkg::SEL_FB_TWO][dpd_pkg::POWER_DOWN_BIT_BIT] & ~ctrl_reg[dpd_pkg::CTRL_HOLD_TWO];

  // Shared reference tick to both channels
  dpd_chan u_synth_channel_one (
    .ref_clk                (ref_clk),
    .resetn                 (resetn),
    .ref_tick               (ref_clock_in),
    .rf_tick                (rf_in_one),
    .ref_divide_value       (word_reg[dpd_pkg::SEL_REF_ONE][dpd_pkg::REF_LSB +: dpd_pkg::REF_W]),
    .swallow_count          (word_reg[dpd_pkg::SEL_FB_ONE][dpd_pkg::SWAL_LSB +: dpd_pkg::SWAL_W]),
    .binary_count           (word_reg[dpd_pkg::SEL_FB_ONE][dpd_pkg::BIN_LSB +: dpd_pkg::BIN_W]),
    .presc_high             (word_reg[dpd_pkg::SEL_FB_ONE][dpd_pkg::PSEL_BIT]),
    .run                    (run[0]),
    .ref_compare_pulse      (ref_compare_pulse[0]),
    .feedback_compare_pulse (feedback_compare_pulse[0]),
    .pump_up                (pump_up[0]),
    .pump_down              (pump_down[0])
  );

  dpd_chan u_synth_channel_two (
    .ref_clk                (ref_clk),
    .resetn                 (resetn),
    .ref_tick               (ref_clock_in),
    .rf_tick                (rf_in_two),
    .ref_divide_value       (word_reg[dpd_pkg::SEL_REF_TWO][dpd_pkg::REF_LSB +: dpd_pkg::REF_W]),
    .swallow_count          (word_reg[dpd_pkg::SEL_FB_TWO][dpd_pkg::SWAL_LSB +: dpd_pkg::SWAL_W]),
    .binary_count           (word_reg[dpd_pkg::SEL_FB_TWO][dpd_pkg::BIN_LSB +: dpd_pkg::BIN_W]),
    .presc_high             (word_reg[dpd_pkg::SEL_FB_TWO][dpd_pkg::PSEL_BIT]),
    .run                    (run[1]),
    .ref_compare_pulse      (ref_compare_pulse[1]),
    .feedback_compare_pulse (feedback_compare_pulse[1]),
    .pump_up                (pump_up[1]),
    .pump_down              (pump_down[1])
  );
endmodule
`default_nettype wire

/* dv/dpd_top_props.sv */
`default_nettype none
module dpd_top_props (
  input wire logic       ref_clk,
  input wire logic       resetn,
  input wire logic       ref_clock_in,
  input wire logic       rf_in_one,
  input wire logic       rf_in_two,
  input wire logic [1:0] ref_compare_pulse,
  input wire logic [1:0] feedback_compare_pulse,
  input wire logic [1:0] pump_up,
  input wire logic [1:0] pump_down
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  a_ref_tick_one: assert property (ref_compare_pulse[0] |-> $past(ref_clock_in))
    else $error("ref pulse one without tick");
  a_ref_tick_two: assert property (ref_compare_pulse[1] |-> $past(ref_clock_in))
    else $error("ref pulse two without tick");
  a_ref_pulse_single: assert property (ref_compare_pulse[0] |=> !ref_compare_pulse[0])
    else $error("ref pulse too long");
  a_fb_tick_one: assert property (feedback_compare_pulse[0] |-> $past(rf_in_one))
    else $error("fb pulse one without rf tick");
  a_fb_tick_two: assert property (feedback_compare_pulse[1] |-> $past(rf_in_two))
    else $error("fb pulse two without rf tick");
  a_fb_pulse_single: assert property (feedback_compare_pulse[1] |=> !feedback_compare_pulse[1])
    else $error("fb pulse too long");
  a_up_cause: assert property ($rose(pump_up[0]) |-> $past(ref_compare_pulse[0]))
    else $error("pump up without ref pulse");
  a_down_cause: assert property ($rose(pump_down[1]) |-> $past(feedback_compare_pulse[1]))
    else $error("pump down without fb pulse");
endmodule
bind dpd_top dpd_top_props u_props (.ref_clk(ref_clk), .resetn(resetn), .ref_clock_in(ref_clock_in),
  .rf_in_one(rf_in_one), .rf_in_two(rf_in_two), .ref_compare_pulse(ref_compare_pulse),
  .feedback_compare_pulse(feedback_compare_pulse), .pump_up(pump_up), .pump_down(pump_down));
`default_nettype wire

/* dv/dpd_host.sv */
`default_nettype none
module dpd_host (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        start,
  input  wire logic [21:0] word,
  output logic             serial_clock,
  output logic             serial_data,
  output logic             latch_strobe,
  output logic             busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] step_reg;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      {busy, serial_clock, serial_data, latch_strobe} <= 4'h0;
      step_reg <= 6'h0;
    end else if (!busy) begin
      serial_data <= ~serial_data;  // Idle data keeps moving
      busy <= start;
      step_reg <= 6'h0;
    end else begin
      step_reg <= step_reg + 6'h1;
      serial_clock <= step_reg[0] && step_reg < 6'h2c;
      if (!step_reg[0] && step_reg < 6'h2c) serial_data <= word[5'h15 - step_reg[5:1]];
      latch_strobe <= step_reg == 6'h2c;
      busy <= step_reg != 6'h2d;
    end
  end
endmodule
`default_nettype wire

/* dv/tb_dual_pll_divider_chain.sv */
`default_nettype none
module tb_dual_pll_divider_chain;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, resetn, tk, start, sclk, sdat, le, busy, bus_write, bus_read;
  logic [7:0]  bus_addr;
  logic [31:0] bus_wdata, bus_rdata;
  logic [21:0] word;
  logic [1:0]  refp, fbp, up, dn;
  int          n_errors, num_checks, cyc;
  int          rc[2], rp[2], fc[2], fp[2];
  dpd_host u_host (.ref_clk(ref_clk), .resetn(resetn), .start(start), .word(word), .serial_clock(sclk),
    .serial_data(sdat), .latch_strobe(le), .busy(busy));
  dpd_top DUT (.ref_clk(ref_clk), .resetn(resetn), .serial_clock(sclk), .serial_data(sdat), .latch_strobe(le),
    .ref_clock_in(tk), .rf_in_one(tk), .rf_in_two(~tk), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata), .ref_compare_pulse(refp),
    .feedback_compare_pulse(fbp), .pump_up(up), .pump_down(dn));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    tk <= ~tk;
    cyc <= cyc + 1;
    // Ticks counted between pulses, per channel
    for (int i = 0; i < 2; i++) begin
      if (refp[i]) begin
        rp[i] = rc[i];
        rc[i] = tk;
      end else rc[i] = rc[i] + tk;
      if (fbp[i]) begin
        fp[i] = fc[i];
        fc[i] = tk ^ i[0];
      end else fc[i] = fc[i] + (tk ^ i[0]);
    end
    if (cyc == 20000) begin
      n_errors++;
      end_of_test();
    end
  end
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    bus_addr <= a;
    bus_wdata <= d;
    bus_write <= 1'b1;
    @(posedge ref_clk);
    bus_write <= 1'b0;
  endtask
  task automatic rd_chk(string name, logic [7:0] a, logic [31:0] m, logic [31:0] exp);
    bus_addr <= a;
    bus_read <= 1'b1;
    @(posedge ref_clk);
    bus_read <= 1'b0;
    #1 chk(name, bus_rdata & m, exp);
    @(posedge ref_clk);
  endtask
  task automatic ld(logic [21:0] w);
    word <= w;
    start <= 1'b1;
    @(posedge ref_clk);
    start <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    while (busy === 1'b1) begin
      @(posedge ref_clk);
      #1;
    end
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic t_serial();
    ld(22'h00000c);
    ld(22'h00001d);
    ld(22'h20060a);
    ld(22'h100607);
    rd_chk("word0", dpd_pkg::OFF_WORD0, 32'h3fffff, 32'h00000c);
    rd_chk("word1", dpd_pkg::OFF_WORD1, 32'h3fffff, 32'h00001d);
    rd_chk("word2", dpd_pkg::OFF_WORD2, 32'h3fffff, 32'h20060a);
    rd_chk("word3", dpd_pkg::OFF_WORD3, 32'h3fffff, 32'h100607);
    rd_chk("status pd", dpd_pkg::OFF_STATUS, 32'hf, 32'h6);
  endtask
  task automatic t_ctrl();
    wr(dpd_pkg::OFF_CTRL, 32'h2);
    rd_chk("ctrl", dpd_pkg::OFF_CTRL, 32'h3, 32'h2);
    rd_chk("status hold", dpd_pkg::OFF_STATUS, 32'hf, 32'hc);
    wr(dpd_pkg::OFF_CTRL, 32'h0);
    rd_chk("unmapped", 8'h20, 32'hffffffff, 32'h0);
    ld(22'h00060a);
    rd_chk("status run", dpd_pkg::OFF_STATUS, 32'hf, 32'h3);
  endtask
  task automatic t_divide();
    repeat (2500) @(posedge ref_clk);
    chk("ref period one", 32'(rp[0]), 32'h3);
    chk("ref period two", 32'(rp[1]), 32'h7);
    chk("fb period one", 32'(fp[0]), 32'(dpd_pkg::PRE_LOW) * 3 + 2);
    chk("fb period two", 32'(fp[1]), 32'(dpd_pkg::PRE_HIGH) * 3 + 1);
    // Both channels held: pumps must drop and status must show both held
    wr(dpd_pkg::OFF_CTRL, 32'h3);
    @(posedge ref_clk);
    #1 chk("pumps held", {28'h0000000, up, dn}, 32'h0);
    @(posedge ref_clk);
    rd_chk("status held", dpd_pkg::OFF_STATUS, 32'hff, 32'hc);
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    {resetn, tk, start, bus_write, bus_read} = 5'h0;
    {word, bus_addr, bus_wdata} = '0;
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    t_serial();
    t_ctrl();
    t_divide();
    end_of_test();
  end
endmodule
`default_nettype wire
